// [common/dsam_regs.svh]
// register offsets, field positions, masks and reset values of the diagnostic and alarm block
`ifndef DSAM_REGS_SVH
`define DSAM_REGS_SVH

// word offsets on the serial port (byte address of the low byte)
`define DSAM_ADDR_THR1      7'h26
`define DSAM_ADDR_THR2      7'h28
`define DSAM_ADDR_SMPL1     7'h2a
`define DSAM_ADDR_SMPL2     7'h2c
`define DSAM_ADDR_CTRL      7'h2e
`define DSAM_ADDR_MISC      7'h34
`define DSAM_ADDR_DIAG      7'h3c

// reset values
`define DSAM_RST_THR        16'h0000
`define DSAM_RST_SMPL       16'h0000
`define DSAM_RST_CTRL       16'h0000
`define DSAM_RST_DIAG       16'h0000

// implemented bits of each register, the rest read as zero
`define DSAM_MASK_THR       16'hbfff
`define DSAM_MASK_SMPL      16'h00ff
`define DSAM_MASK_CTRL      16'hffd7
`define DSAM_MASK_MISC      16'h0c00

// misc_control fields
`define DSAM_MISC_MEMTEST   11
`define DSAM_MISC_SELFTEST  10

// alarm_control fields
`define DSAM_CTRL_A2_SRC_HI 15
`define DSAM_CTRL_A2_SRC_LO 12
`define DSAM_CTRL_A1_SRC_HI 11
`define DSAM_CTRL_A1_SRC_LO 8
`define DSAM_CTRL_A2_ROC    7
`define DSAM_CTRL_A1_ROC    6
`define DSAM_CTRL_FILT      4
`define DSAM_CTRL_OUT_EN    2
`define DSAM_CTRL_OUT_POL   1
`define DSAM_CTRL_OUT_SEL   0

// threshold fields
`define DSAM_THR_POL        15
`define DSAM_THR_VAL_HI     13

// diagnostic_flags fields
`define DSAM_DIAG_ST_HI     15
`define DSAM_DIAG_ST_LO     10
`define DSAM_DIAG_ALM2      9
`define DSAM_DIAG_ALM1      8
`define DSAM_DIAG_UNUSED    7
`define DSAM_DIAG_FLASH_CK  6
`define DSAM_DIAG_ST_DIAG   5
`define DSAM_DIAG_OVR       4
`define DSAM_DIAG_COMM      3
`define DSAM_DIAG_FL_UPD    2
`define DSAM_DIAG_SUP_HI    1
`define DSAM_DIAG_SUP_LO    0

// serial frame and highest alarm source code
`define DSAM_FRAME_LAST     4'hf
`define DSAM_SRC_LAST       4'hb

`endif

// [common/dsam_pkg.sv]
// types shared by the diagnostic and alarm block
package dsam_pkg;
	typedef enum logic [2:0] {
		DSAM_TST_IDLE = 3'b001,
		DSAM_TST_MEM  = 3'b010,
		DSAM_TST_SELF = 3'b100
	} dsam_test_e;

	typedef enum logic [3:0] {
		DSAM_SRC_OFF     = 4'h0,
		DSAM_SRC_SUPPLY  = 4'h1,
		DSAM_SRC_GYRO_X  = 4'h2,
		DSAM_SRC_GYRO_Y  = 4'h3,
		DSAM_SRC_GYRO_Z  = 4'h4,
		DSAM_SRC_ACCEL_X = 4'h5,
		DSAM_SRC_ACCEL_Y = 4'h6,
		DSAM_SRC_ACCEL_Z = 4'h7,
		DSAM_SRC_TEMP_X  = 4'h8,
		DSAM_SRC_TEMP_Y  = 4'h9,
		DSAM_SRC_TEMP_Z  = 4'ha,
		DSAM_SRC_AUX_ADC = 4'hb
	} dsam_src_e;

	typedef logic [13:0] dsam_data_t;
endpackage

// [verilog/dsam_monitor.sv]
// diagnostic flags, test launch and dual alarm monitor behind the serial register port
//
// Contract
// - memory test bit runs checksum, result to bit6
// - reading diagnostic_flags clears all flags
// - persisting error sets flag again next sample
// - supply flags clear themselves when back in range
// - bits 15:10 report accel and gyro self-test failures
// - bit9 alarm2, bit8 alarm1 active, bit7 unused
// - bits 6..2 flag checksum, diag, overrange, comm, flash
// - bit1 supply too high, bit0 too low
// - two independent alarms with own threshold, count
// - threshold bit15 picks greater or less compare
// - threshold 13:0 in source data format
// - rate period is count times sample period
// - sample count zero and one mean one
// - alarm2 source field decodes eleven sources or off
// - alarm1 source field uses same encoding
// - control bits 7,6 choose rate or static
// - control bit4 selects filtered or raw data
// - bits 2,1,0 enable, polarity, line of output
// - self-test bit self-clears, results into flags
// - memory test bit self-clears on completion
`timescale 1ns/1ns
`include "dsam_regs.svh"

module dsam_monitor (
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_sclk,
	input  wire logic                  i_cs_n,
	input  wire logic                  i_mosi,
	output logic                       o_miso,
	input  wire logic                  i_sample_tick,
	input  wire logic [11:1][13:0]     i_raw_data,
	input  wire logic [11:1][13:0]     i_filt_data,
	input  wire logic                  i_overrange,
	input  wire logic                  i_comm_fail,
	input  wire logic                  i_flash_update_fail,
	input  wire logic                  i_supply_high,
	input  wire logic                  i_supply_low,
	output logic                       o_memtest_run,
	input  wire logic                  i_memtest_done,
	input  wire logic                  i_memtest_fail,
	output logic                       o_selftest_run,
	input  wire logic                  i_selftest_done,
	input  wire logic [5:0]            i_selftest_fail,
	input  wire logic                  i_selftest_diag_err,
	output logic                       o_line1_level,
	output logic                       o_line1_oe_n,
	output logic                       o_line2_level,
	output logic                       o_line2_oe_n
);

	function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
		input logic [7:0] data);
		put_byte = hi ? {data, old[7:0]} : {old[15:8], data};
	endfunction

	function automatic dsam_pkg::dsam_data_t pick_src(input logic [3:0] sel,
		input logic [11:1][13:0] raw, input logic [11:1][13:0] filt, input logic use_f);
		pick_src = 14'h0000;
		if (sel != 4'h0 && sel <= `DSAM_SRC_LAST) begin
			pick_src = use_f ? filt[sel] : raw[sel];
		end
	endfunction

	// signed compare; threshold sign-extended from bit 13
	function automatic logic thr_hit(input logic [14:0] value, input logic [15:0] thr);
		logic signed [14:0] v;
		logic signed [14:0] t;
		v = value;
		t = {thr[`DSAM_THR_VAL_HI], thr[13:0]};
		thr_hit = thr[`DSAM_THR_POL] ? (v > t) : (v < t);
	endfunction

	// ---------------- link domain, clocked by the host's serial clock
	logic [3:0]  bit_cnt_ff;
	logic [15:0] rx_sh_ff;
	logic [15:0] rx_word_ff;
	logic        rx_full_ff;
	logic [15:0] tx_sh_ff;
	logic [15:0] resp_ff;

	// counter and shifter end with the frame: chip select clears them
	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt_ff <= 4'h0;
			rx_sh_ff   <= 16'h0000;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
			rx_sh_ff   <= {rx_sh_ff[14:0], i_mosi};
		end
	end

	// word and valid flag hold while select is high; core reads them then
	always_ff @(posedge i_sclk) begin
		if (bit_cnt_ff == `DSAM_FRAME_LAST) begin
			rx_word_ff <= {rx_sh_ff[14:0], i_mosi};
			rx_full_ff <= 1'b1;
		end else if (bit_cnt_ff == 4'h0) begin
			rx_full_ff <= 1'b0;
		end
	end

	// resp_ff changes only between frames, so loading it on the first edge is safe
	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			tx_sh_ff <= 16'h0000;
			o_miso   <= 1'b0;
		end else if (bit_cnt_ff == 4'h0) begin
			tx_sh_ff <= {resp_ff[14:0], 1'b0};
			o_miso   <= resp_ff[15];
		end else begin
			tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
			o_miso   <= tx_sh_ff[15];
		end
	end

	// ---------------- core domain
	logic cs_s1_ff;
	logic cs_s2_ff;
	logic cs_s3_ff;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
		end else begin
			cs_s1_ff <= i_cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
		end
	end

	wire       frame_end = cs_s2_ff & ~cs_s3_ff;
	wire       cmd_valid = frame_end & rx_full_ff;
	wire       cmd_wr    = cmd_valid & rx_word_ff[15];
	wire       cmd_rd    = cmd_valid & ~rx_word_ff[15];
	wire [6:0] cmd_addr  = rx_word_ff[14:8];
	wire       cmd_hi    = cmd_addr[0];
	wire [7:0] cmd_data  = rx_word_ff[7:0];
	wire [6:0] word_addr = {cmd_addr[6:1], 1'b0};

	logic [2:1][15:0]      thr_ff;
	logic [2:1][15:0]      smpl_ff;
	logic [15:0]           ctrl_ff;
	logic                  memtest_ff;
	logic                  selftest_ff;
	logic [15:0]           diag_ff;
	dsam_pkg::dsam_test_e  test_ff;
	dsam_pkg::dsam_test_e  nxt_test;

	wire [15:0] misc_rd   = {4'h0, memtest_ff, selftest_ff, 10'h000};
	wire        wr_thr1   = cmd_wr && (word_addr == `DSAM_ADDR_THR1);
	wire        wr_thr2   = cmd_wr && (word_addr == `DSAM_ADDR_THR2);
	wire        wr_smpl1  = cmd_wr && (word_addr == `DSAM_ADDR_SMPL1);
	wire        wr_smpl2  = cmd_wr && (word_addr == `DSAM_ADDR_SMPL2);
	wire        wr_ctrl   = cmd_wr && (word_addr == `DSAM_ADDR_CTRL);
	wire        wr_misc   = cmd_wr && (word_addr == `DSAM_ADDR_MISC);
	wire        rd_diag   = cmd_rd && (word_addr == `DSAM_ADDR_DIAG);

	wire [15:0] nxt_thr1  = put_byte(thr_ff[1], cmd_hi, cmd_data) & `DSAM_MASK_THR;
	wire [15:0] nxt_thr2  = put_byte(thr_ff[2], cmd_hi, cmd_data) & `DSAM_MASK_THR;
	wire [15:0] nxt_smpl1 = put_byte(smpl_ff[1], cmd_hi, cmd_data) & `DSAM_MASK_SMPL;
	wire [15:0] nxt_smpl2 = put_byte(smpl_ff[2], cmd_hi, cmd_data) & `DSAM_MASK_SMPL;
	wire [15:0] nxt_ctrl  = put_byte(ctrl_ff, cmd_hi, cmd_data) & `DSAM_MASK_CTRL;
	wire [15:0] nxt_misc  = put_byte(misc_rd, cmd_hi, cmd_data) & `DSAM_MASK_MISC;

	// writing zero cannot abort a running test; only completion clears the bits
	wire        start_mem  = wr_misc & nxt_misc[`DSAM_MISC_MEMTEST];
	wire        start_self = wr_misc & nxt_misc[`DSAM_MISC_SELFTEST];
	wire        mem_done   = (test_ff == dsam_pkg::DSAM_TST_MEM) & i_memtest_done;
	wire        self_done  = (test_ff == dsam_pkg::DSAM_TST_SELF) & i_selftest_done;

	wire [15:0] rd_data =
		(word_addr == `DSAM_ADDR_THR1)  ? thr_ff[1]  :
		(word_addr == `DSAM_ADDR_THR2)  ? thr_ff[2]  :
		(word_addr == `DSAM_ADDR_SMPL1) ? smpl_ff[1] :
		(word_addr == `DSAM_ADDR_SMPL2) ? smpl_ff[2] :
		(word_addr == `DSAM_ADDR_CTRL)  ? ctrl_ff    :
		(word_addr == `DSAM_ADDR_MISC)  ? misc_rd    :
		(word_addr == `DSAM_ADDR_DIAG)  ? diag_ff    : 16'h0000;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			thr_ff[1]  <= `DSAM_RST_THR;
			thr_ff[2]  <= `DSAM_RST_THR;
			smpl_ff[1] <= `DSAM_RST_SMPL;
			smpl_ff[2] <= `DSAM_RST_SMPL;
			ctrl_ff    <= `DSAM_RST_CTRL;
			resp_ff    <= 16'h0000;
		end else begin
			if (wr_thr1) thr_ff[1] <= nxt_thr1;
			if (wr_thr2) thr_ff[2] <= nxt_thr2;
			if (wr_smpl1) smpl_ff[1] <= nxt_smpl1;
			if (wr_smpl2) smpl_ff[2] <= nxt_smpl2;
			if (wr_ctrl) ctrl_ff <= nxt_ctrl;
			if (cmd_rd) resp_ff <= rd_data;
		end
	end

	// test launcher: memory test first if both are requested
	always_comb begin
		nxt_test = test_ff;
		case (test_ff)
			dsam_pkg::DSAM_TST_IDLE: begin
				if (memtest_ff) nxt_test = dsam_pkg::DSAM_TST_MEM;
				else if (selftest_ff) nxt_test = dsam_pkg::DSAM_TST_SELF;
			end
			dsam_pkg::DSAM_TST_MEM: begin
				if (i_memtest_done) nxt_test = dsam_pkg::DSAM_TST_IDLE;
			end
			dsam_pkg::DSAM_TST_SELF: begin
				if (i_selftest_done) nxt_test = dsam_pkg::DSAM_TST_IDLE;
			end
			default: nxt_test = dsam_pkg::DSAM_TST_IDLE;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			test_ff        <= dsam_pkg::DSAM_TST_IDLE;
			memtest_ff     <= 1'b0;
			selftest_ff    <= 1'b0;
			o_memtest_run  <= 1'b0;
			o_selftest_run <= 1'b0;
		end else begin
			test_ff        <= nxt_test;
			memtest_ff     <= start_mem | (memtest_ff & ~mem_done);
			selftest_ff    <= start_self | (selftest_ff & ~self_done);
			o_memtest_run  <= nxt_test == dsam_pkg::DSAM_TST_MEM;
			o_selftest_run <= nxt_test == dsam_pkg::DSAM_TST_SELF;
		end
	end

	// ---------------- alarm engines
	// unpacked so each engine's process owns its own elements
	logic             act_ff    [2:1];
	logic [7:0]       cnt_ff    [2:1];
	logic [13:0]      ref_ff    [2:1];
	logic             primed_ff [2:1];
	wire  [2:1][3:0]  alm_src = {ctrl_ff[`DSAM_CTRL_A2_SRC_HI:`DSAM_CTRL_A2_SRC_LO],
		ctrl_ff[`DSAM_CTRL_A1_SRC_HI:`DSAM_CTRL_A1_SRC_LO]};
	wire  [2:1]       alm_roc = {ctrl_ff[`DSAM_CTRL_A2_ROC], ctrl_ff[`DSAM_CTRL_A1_ROC]};

	genvar k;
	generate
		for (k = 1; k <= 2; k++) begin : g_alarm
			wire [13:0] cur    = pick_src(alm_src[k], i_raw_data, i_filt_data,
				ctrl_ff[`DSAM_CTRL_FILT]);
			wire [7:0]  span   = (smpl_ff[k][7:0] <= 8'h01) ? 8'h01 : smpl_ff[k][7:0];
			wire        win    = (cnt_ff[k] + 8'h01) >= span;
			wire [14:0] delta  = {cur[13], cur} - {ref_ff[k][13], ref_ff[k]};
			wire        st_hit = thr_hit({cur[13], cur}, thr_ff[k]);
			wire        rc_hit = thr_hit(delta, thr_ff[k]);

			// window restarts when a source is switched off or the alarm is set to static, not on other edits
			always_ff @(posedge i_clock) begin
				if (!i_rst_n) begin
					act_ff[k]    <= 1'b0;
					cnt_ff[k]    <= 8'h00;
					ref_ff[k]    <= 14'h0000;
					primed_ff[k] <= 1'b0;
				end else if (i_sample_tick) begin
					if (alm_src[k] == dsam_pkg::DSAM_SRC_OFF) begin
						act_ff[k]    <= 1'b0;
						cnt_ff[k]    <= 8'h00;
						primed_ff[k] <= 1'b0;
					end else if (!alm_roc[k]) begin
						act_ff[k]    <= st_hit;
						cnt_ff[k]    <= 8'h00;
						primed_ff[k] <= 1'b0;
					end else if (!primed_ff[k]) begin
						ref_ff[k]    <= cur;
						cnt_ff[k]    <= 8'h00;
						primed_ff[k] <= 1'b1;
					end else if (win) begin
						act_ff[k] <= rc_hit;
						ref_ff[k] <= cur;
						cnt_ff[k] <= 8'h00;
					end else begin
						cnt_ff[k] <= cnt_ff[k] + 8'h01;
					end
				end
			end
		end
	endgenerate

	// ---------------- diagnostic flags
	wire [15:0] set_vec;
	wire [15:0] clr_vec;
	assign set_vec[`DSAM_DIAG_ST_HI:`DSAM_DIAG_ST_LO] = self_done ? i_selftest_fail : 6'h00;
	assign set_vec[`DSAM_DIAG_ALM2]     = i_sample_tick & act_ff[2];
	assign set_vec[`DSAM_DIAG_ALM1]     = i_sample_tick & act_ff[1];
	assign set_vec[`DSAM_DIAG_UNUSED]   = 1'b0;
	assign set_vec[`DSAM_DIAG_FLASH_CK] = mem_done & i_memtest_fail;
	assign set_vec[`DSAM_DIAG_ST_DIAG]  = self_done & i_selftest_diag_err;
	assign set_vec[`DSAM_DIAG_OVR]      = i_sample_tick & i_overrange;
	assign set_vec[`DSAM_DIAG_COMM]     = i_sample_tick & i_comm_fail;
	assign set_vec[`DSAM_DIAG_FL_UPD]   = i_sample_tick & i_flash_update_fail;
	assign set_vec[`DSAM_DIAG_SUP_HI]   = i_sample_tick & i_supply_high;
	assign set_vec[`DSAM_DIAG_SUP_LO]   = i_sample_tick & i_supply_low;

	// a completed test also clears a stale fail; a read clears everything
	assign clr_vec = rd_diag ? 16'hffff : {
		{6{self_done}}, 3'b000, mem_done, self_done, 3'b000,
		i_sample_tick & ~i_supply_high, i_sample_tick & ~i_supply_low};

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			diag_ff <= `DSAM_RST_DIAG;
		end else begin
			diag_ff <= (diag_ff & ~clr_vec) | set_vec;
		end
	end

	// ---------------- alarm output line
	wire any_act    = act_ff[1] | act_ff[2];
	wire out_level  = ctrl_ff[`DSAM_CTRL_OUT_POL] ? any_act : ~any_act;
	wire drive1     = ctrl_ff[`DSAM_CTRL_OUT_EN] & ~ctrl_ff[`DSAM_CTRL_OUT_SEL];
	wire drive2     = ctrl_ff[`DSAM_CTRL_OUT_EN] & ctrl_ff[`DSAM_CTRL_OUT_SEL];

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_line1_level <= 1'b0;
			o_line1_oe_n  <= 1'b1;
			o_line2_level <= 1'b0;
			o_line2_oe_n  <= 1'b1;
		end else begin
			o_line1_level <= drive1 & out_level;
			o_line1_oe_n  <= ~drive1;
			o_line2_level <= drive2 & out_level;
			o_line2_oe_n  <= ~drive2;
		end
	end

	// ---------------- checks
	diag_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(rd_diag && set_vec == 16'h0000) |=> diag_ff == 16'h0000)
		else $error("diagnostic flags not cleared by read");

	flag_return_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(rd_diag && i_sample_tick && i_overrange) |=> diag_ff[`DSAM_DIAG_OVR])
		else $error("overrange flag lost in read cycle");

	supply_auto_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_sample_tick && !i_supply_high && !i_supply_low) |=> diag_ff[1:0] == 2'b00)
		else $error("supply flags did not clear themselves");

	selftest_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(self_done && !start_self) |=> (diag_ff[15:10] == $past(i_selftest_fail)) && !selftest_ff
		##1 !o_selftest_run)
		else $error("self-test results or completion wrong");

	memtest_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(mem_done && !start_mem) |=> (diag_ff[6] == $past(i_memtest_fail)) && !memtest_ff)
		else $error("memory test result or completion wrong");

	alarm_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_sample_tick && act_ff[1] && !act_ff[2]) |=> diag_ff[8] && !diag_ff[7])
		else $error("alarm 1 status not flagged");

	alarm_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_sample_tick && alm_src[1] == 4'h0) |=> !act_ff[1] && cnt_ff[1] == 8'h00)
		else $error("disabled alarm 1 still active");

	single_sample_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_sample_tick && alm_roc[1] && primed_ff[1] && smpl_ff[1][7:1] == 7'h00
		&& alm_src[1] != 4'h0) |=> cnt_ff[1] == 8'h00)
		else $error("count of zero or one not one sample");

	line_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		drive1 |=> !o_line1_oe_n && o_line2_oe_n && (o_line1_level == $past(out_level)))
		else $error("alarm line 1 not driven with chosen polarity");

endmodule

// [testbench/dsam_host_model.sv]
// host side of the serial port: 16-bit mode 3 frames, msb first
`timescale 1ns/1ns

module dsam_host_model (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_mosi,
	input  wire logic i_miso
);
	localparam int HALF_NS = 6;

	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// clock stands high outside frames; the long gap lets the core load command and reply
	task automatic xfer(input logic [15:0] word, output logic [15:0] rx);
		o_cs_n = 1'b0;
		#(HALF_NS);
		for (int b = 15; b >= 0; b--) begin
			o_sclk = 1'b0;
			o_mosi = word[b];
			#(HALF_NS);
			o_sclk = 1'b1;
			rx[b] = i_miso;
			#(HALF_NS);
		end
		o_cs_n = 1'b1;
		// released data line flips so a stale bit cannot pass for a good one
		o_mosi = ~o_mosi;
		#(10 * HALF_NS + 40);
	endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench of the diagnostic flags and alarm monitor
`timescale 1ns/1ns
`include "dsam_regs.svh"

module tb_top;
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic              tick_p = 1'b0;
	logic              ovr = 1'b0;
	logic              comm = 1'b0;
	logic              flupd = 1'b0;
	logic              sup_hi = 1'b0;
	logic              sup_lo = 1'b0;
	logic              mt_done = 1'b0;
	logic              mt_fail = 1'b0;
	logic              st_done = 1'b0;
	logic [5:0]        st_fail = 6'h00;
	logic              st_err = 1'b0;
	logic [11:1][13:0] raw_data = '0;
	logic [11:1][13:0] filt_data = '0;
	wire               sclk, cs_n, mosi, miso, mt_run, st_run;
	wire               l1, l1_oe_n, l2, l2_oe_n;
	int                mismatches = 0;
	int                samples_checked = 0;

	always #5 clock = ~clock;

	dsam_monitor i_dsam_monitor (.i_clock(clock), .i_rst_n(rst_n), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .i_sample_tick(tick_p),
		.i_raw_data(raw_data), .i_filt_data(filt_data), .i_overrange(ovr),
		.i_comm_fail(comm), .i_flash_update_fail(flupd), .i_supply_high(sup_hi),
		.i_supply_low(sup_lo), .o_memtest_run(mt_run), .i_memtest_done(mt_done),
		.i_memtest_fail(mt_fail), .o_selftest_run(st_run), .i_selftest_done(st_done),
		.i_selftest_fail(st_fail), .i_selftest_diag_err(st_err), .o_line1_level(l1),
		.o_line1_oe_n(l1_oe_n), .o_line2_level(l2), .o_line2_oe_n(l2_oe_n));

	dsam_host_model i_dsam_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
		.i_miso(miso));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr8(input logic [6:0] addr, input logic [7:0] val);
		logic [15:0] rx;
		i_dsam_host_model.xfer({1'b1, addr, val}, rx);
	endtask

	task automatic wr(input logic [6:0] addr, input logic [15:0] val);
		wr8(addr + 7'h01, val[15:8]);
		wr8(addr, val[7:0]);
	endtask

	// reply comes in the following frame, which reads an unmapped place
	task automatic rdchk(input string what, input logic [6:0] addr, input logic [15:0] exp);
		logic [15:0] rx;
		i_dsam_host_model.xfer({1'b0, addr, 8'h00}, rx);
		i_dsam_host_model.xfer(16'h0000, rx);
		chk16(what, exp, rx);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clock);
			tick_p <= 1'b1;
			@(posedge clock);
			tick_p <= 1'b0;
		end
		repeat (3) @(posedge clock);
	endtask

	task automatic wait_run(input bit self);
		for (int k = 0; k < 40; k++) begin
			@(negedge clock);
			if ((self ? st_run : mt_run) === 1'b1)
				return;
		end
		mismatches++;
		$display("[FAIL] test run flag expected 1 seen 0");
		wrap_up();
	endtask

	task automatic sc_reset();
		logic [6:0] addrs [7] = '{`DSAM_ADDR_THR1, `DSAM_ADDR_THR2, `DSAM_ADDR_SMPL1,
			`DSAM_ADDR_SMPL2, `DSAM_ADDR_CTRL, `DSAM_ADDR_MISC, `DSAM_ADDR_DIAG};
		for (int i = 0; i < 7; i++)
			rdchk("reset value", addrs[i], 16'h0000);
		chk1("line1 enable", 1'b1, l1_oe_n);
		chk1("line2 enable", 1'b1, l2_oe_n);
		chk1("memtest run", 1'b0, mt_run);
		wr(`DSAM_ADDR_DIAG, 16'hffff);
		rdchk("flags write", `DSAM_ADDR_DIAG, 16'h0000);
		rdchk("unmapped", 7'h40, 16'h0000);
	endtask

	task automatic sc_masks();
		logic [6:0]  addrs [5] = '{`DSAM_ADDR_THR1, `DSAM_ADDR_THR2, `DSAM_ADDR_SMPL1,
			`DSAM_ADDR_SMPL2, `DSAM_ADDR_CTRL};
		logic [15:0] masks [5] = '{16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff, 16'hffd7};
		for (int i = 0; i < 5; i++) begin
			wr(addrs[i], 16'hffff);
			rdchk("unused bits", addrs[i], masks[i]);
			wr(addrs[i], 16'h0000);
		end
	endtask

	task automatic sc_memtest();
		wr8(`DSAM_ADDR_MISC + 7'h01, 8'h08);
		wait_run(1'b0);
		@(posedge clock);
		mt_done <= 1'b1;
		mt_fail <= 1'b1;
		@(posedge clock);
		mt_done <= 1'b0;
		repeat (3) @(posedge clock);
		chk1("memtest run", 1'b0, mt_run);
		rdchk("misc after memtest", `DSAM_ADDR_MISC, 16'h0000);
		rdchk("checksum flag", `DSAM_ADDR_DIAG, 16'h0040);
		rdchk("flags reread", `DSAM_ADDR_DIAG, 16'h0000);
	endtask

	task automatic sc_selftest();
		wr8(`DSAM_ADDR_MISC + 7'h01, 8'h04);
		wait_run(1'b1);
		@(posedge clock);
		st_done <= 1'b1;
		st_fail <= 6'b100101;
		st_err <= 1'b1;
		@(posedge clock);
		st_done <= 1'b0;
		repeat (3) @(posedge clock);
		chk1("selftest run", 1'b0, st_run);
		rdchk("misc after selftest", `DSAM_ADDR_MISC, 16'h0000);
		rdchk("selftest flags", `DSAM_ADDR_DIAG, 16'h9420);
	endtask

	task automatic sc_flags();
		@(posedge clock);
		{ovr, comm, flupd, sup_hi} <= 4'hf;
		tick(1);
		rdchk("event flags", `DSAM_ADDR_DIAG, 16'h001e);
		{comm, flupd, sup_hi, sup_lo} <= 4'h1;
		tick(1);
		rdchk("persisting flags", `DSAM_ADDR_DIAG, 16'h0011);
		ovr <= 1'b0;
		tick(1);
		sup_lo <= 1'b0;
		tick(1);
		rdchk("supply back in range", `DSAM_ADDR_DIAG, 16'h0000);
	endtask

	task automatic sc_static();
		wr(`DSAM_ADDR_THR1, 16'h8064);
		wr(`DSAM_ADDR_THR2, 16'h0032);
		for (int s = 1; s <= 11; s++) begin
			@(posedge clock);
			raw_data <= '0;
			filt_data <= '0;
			// only the chosen filtered source trips alarm 1 and keeps alarm 2 quiet
			raw_data[s] <= 14'h3ff6;
			filt_data[s] <= 14'd200;
			wr(`DSAM_ADDR_CTRL, {s[3:0], s[3:0], 8'h17});
			tick(2);
			chk1("line2 level", 1'b1, l2);
			chk1("line2 enable", 1'b0, l2_oe_n);
			chk1("line1 enable", 1'b1, l1_oe_n);
			rdchk("alarm flags", `DSAM_ADDR_DIAG, 16'h0100);
		end
		wr8(`DSAM_ADDR_CTRL, 8'h15);
		tick(1);
		chk1("line2 active low", 1'b0, l2);
		chk1("line2 enable", 1'b0, l2_oe_n);
		wr8(`DSAM_ADDR_CTRL, 8'h11);
		tick(1);
		chk1("line2 disabled", 1'b1, l2_oe_n);
	endtask

	task automatic sc_rate();
		@(posedge clock);
		raw_data <= '0;
		filt_data <= '0;
		wr(`DSAM_ADDR_THR1, 16'h8032);
		// static pass on zero data drops the alarm left from the previous scenario
		tick(1);
		wr(`DSAM_ADDR_SMPL1, 16'h0000);
		wr(`DSAM_ADDR_CTRL, 16'h0546);
		tick(1);
		chk1("rate primed", 1'b0, l1);
		raw_data[5] <= 14'd100;
		tick(1);
		chk1("rate alarm", 1'b1, l1);
		chk1("line1 enable", 1'b0, l1_oe_n);
		tick(1);
		chk1("rate alarm idle", 1'b0, l1);
		wr(`DSAM_ADDR_SMPL1, 16'h0003);
		raw_data[5] <= 14'd200;
		tick(2);
		chk1("rate window open", 1'b0, l1);
		tick(1);
		chk1("rate window end", 1'b1, l1);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		sc_reset();
		sc_masks();
		sc_memtest();
		sc_selftest();
		sc_flags();
		sc_static();
		sc_rate();
		wrap_up();
	end
endmodule
